//--- pab_port_ab.v
// Two 8-bit ports with Port B alternate-function override logic
//
// Contract
// - Bit 0 carries timer1 compare A when position U select is set.
// - Three-wire data input leaves bit 0 control untouched; keep it input.
// - Bit 0 is the bidirectional two-wire data line in two-wire mode.
// - Bit 0 feeds pin-change source eight; input kept enabled when masked.
// - Bits 7..4 only take compare B or A output value when selected.
// - Two-wire bits 2,0: direction (hold/shift or port) and dir; drive low.
// - Per-pin override enables and values beat normal port registers.
// - Port A output data is 8-bit read/write, reset zero.
// - Port A direction is 8-bit read/write, reset zero (all inputs).
// - Port A input reads pin levels; writes are a special action.
// - Port B output data is 8-bit read/write, reset zero.
// - Port B direction is 8-bit read/write, reset zero.
// - Port B input reads pin levels; writes are a special action.
// - Three-wire data out on bit 1 overrides port bit when output; the code needs two-wire, three-wire and pos bits all set.
`timescale 1ns/10ps
`include "pab_map.vh"
module pab_port_ab (
    clk,
    srst,
    clkEn,
    avsAddress,
    avsRead,
    avsWrite,
    avsWriteData,
    avsByteEnable,
    avsReadData,
    avsWaitRequest,
    timer1CmpA,
    timer1CmpB,
    serialShiftOutBit,
    serialClockStretch,
    serialToggleEnable,
    portAIn,
    portAOut,
    portAOutEnN,
    portAPullUp,
    portBIn,
    portBOut,
    portBOutEnN,
    portBPullUp,
    portBToggle,
    portBInputEnable,
    serialDataIn,
    serialClockIn,
    pinChangeSourceEight
);
    input wire clk;
    input wire srst;
    input wire clkEn;
    input wire [`PAB_ADDR_W-1:0] avsAddress;
    input wire avsRead;
    input wire avsWrite;
    input wire [31:0] avsWriteData;
    input wire [3:0] avsByteEnable;
    output reg [31:0] avsReadData;
    output wire avsWaitRequest;
    input wire timer1CmpA;
    input wire timer1CmpB;
    input wire serialShiftOutBit;
    input wire serialClockStretch;
    input wire serialToggleEnable;
    input wire [7:0] portAIn;
    output wire [7:0] portAOut;
    output wire [7:0] portAOutEnN;
    output wire [7:0] portAPullUp;
    input wire [7:0] portBIn;
    output wire [7:0] portBOut;
    output wire [7:0] portBOutEnN;
    output wire [7:0] portBPullUp;
    output wire [7:0] portBToggle;
    output wire [7:0] portBInputEnable;
    output wire serialDataIn;
    output wire serialClockIn;
    output wire pinChangeSourceEight;

    reg [7:0] aOut_q;
    reg [7:0] aDir_q;
    reg [7:0] bOut_q;
    reg [7:0] bDir_q;
    reg [7:0] ctrl_q;
    reg [7:0] sel_q;
    reg ack_q;
    wire [7:0] aSync;
    wire [7:0] bSync;
    wire access;
    wire wrLane;

    // One wait cycle per access so read data come from a register
    assign access = (avsRead | avsWrite) & clkEn;
    assign avsWaitRequest = (avsRead | avsWrite) & ~ack_q;
    assign wrLane = avsWrite & avsByteEnable[0] & ~ack_q & clkEn;

    pab_pin_sync #(.W(8)) uSyncA (
        .clk(clk),
        .srst(srst),
        .clkEn(clkEn),
        .din(portAIn),
        .dout(aSync)
    );
    pab_pin_sync #(.W(8)) uSyncB (
        .clk(clk),
        .srst(srst),
        .clkEn(clkEn),
        .din(portBIn),
        .dout(bSync)
    );

    // Register file
    always @(posedge clk) begin
        if (srst) begin
            aOut_q <= `PAB_RST_BYTE;
            aDir_q <= `PAB_RST_BYTE;
            bOut_q <= `PAB_RST_BYTE;
            bDir_q <= `PAB_RST_BYTE;
            ctrl_q <= `PAB_RST_BYTE;
            sel_q <= `PAB_RST_BYTE;
            ack_q <= 1'b0;
            avsReadData <= 32'h00000000;
        end else if (clkEn) begin
            ack_q <= access & ~ack_q;
            if (wrLane) begin
                case (avsAddress)
                    `PAB_OFS_A_OUT: aOut_q <= avsWriteData[7:0];
                    `PAB_OFS_A_DIR: aDir_q <= avsWriteData[7:0];
                    // Input write toggles set bits only
                    `PAB_OFS_A_PIN: aOut_q <= aOut_q ^ avsWriteData[7:0];
                    `PAB_OFS_B_OUT: bOut_q <= avsWriteData[7:0];
                    `PAB_OFS_B_DIR: bDir_q <= avsWriteData[7:0];
                    `PAB_OFS_B_PIN: bOut_q <= bOut_q ^ avsWriteData[7:0];
                    `PAB_OFS_CTRL: ctrl_q <= avsWriteData[7:0];
                    `PAB_OFS_SEL: sel_q <= avsWriteData[7:0];
                    default: ;
                endcase
            end
            if (avsRead & ~ack_q) begin
                case (avsAddress)
                    `PAB_OFS_A_OUT: avsReadData <= {`PAB_ZERO_HI, aOut_q};
                    `PAB_OFS_A_DIR: avsReadData <= {`PAB_ZERO_HI, aDir_q};
                    `PAB_OFS_A_PIN: avsReadData <= {`PAB_ZERO_HI, aSync};
                    `PAB_OFS_B_OUT: avsReadData <= {`PAB_ZERO_HI, bOut_q};
                    `PAB_OFS_B_DIR: avsReadData <= {`PAB_ZERO_HI, bDir_q};
                    `PAB_OFS_B_PIN: avsReadData <= {`PAB_ZERO_HI, bSync};
                    `PAB_OFS_CTRL: avsReadData <= {`PAB_ZERO_HI, ctrl_q};
                    `PAB_OFS_SEL: avsReadData <= {`PAB_ZERO_HI, sel_q};
                    default: avsReadData <= 32'h00000000;
                endcase
            end
        end
    end

    // Port A has no alternate functions here
    assign portAOut = aOut_q;
    assign portAOutEnN = ~aDir_q;
    assign portAPullUp = aOut_q & ~aDir_q;

    // Control decode
    wire twoW = ctrl_q[`PAB_C_TWO];
    wire threeW = ctrl_q[`PAB_C_THREE];
    wire pos = ctrl_q[`PAB_C_POS];
    wire sie = ctrl_q[`PAB_C_SIE];
    wire pin_change_group1_enable = ctrl_q[`PAB_C_PIN_CHANGE_GROUP1_ENABLE];
    wire mask8 = ctrl_q[`PAB_C_MASK8];
    wire enA = ctrl_q[`PAB_C_ENA];
    wire enB = ctrl_q[`PAB_C_ENB];
    wire twoPos = twoW & pos;
    // Overrides kept literal, including the two-and-three-wire term on bit 1
    wire dataOutSel = twoW & threeW & pos;

    reg [7:0] direction_override_enable;
    reg [7:0] direction_override_value;
    reg [7:0] out_value_override_enable;
    reg [7:0] out_value_override_value;
    reg [7:0] toggle_override_enable;
    reg [7:0] input_enable_override_enable;
    reg [7:0] input_enable_override_value;
    always @* begin
        direction_override_enable = `PAB_ZERO_BYTE;
        direction_override_value = `PAB_ZERO_BYTE;
        out_value_override_enable = `PAB_ZERO_BYTE;
        out_value_override_value = `PAB_ZERO_BYTE;
        toggle_override_enable = `PAB_ZERO_BYTE;
        input_enable_override_enable = `PAB_ZERO_BYTE;
        input_enable_override_value = `PAB_ZERO_BYTE;
        // Bits 7..3: value only
        out_value_override_enable[`PAB_B7] = enB & sel_q[`PAB_S_BX];
        out_value_override_value[`PAB_B7] = timer1CmpB;
        out_value_override_enable[`PAB_B6] = enA & sel_q[`PAB_S_AX];
        out_value_override_value[`PAB_B6] = timer1CmpA;
        out_value_override_enable[`PAB_B5] = enB & sel_q[`PAB_S_BW];
        out_value_override_value[`PAB_B5] = timer1CmpB;
        out_value_override_enable[`PAB_B4] = enA & sel_q[`PAB_S_AW];
        out_value_override_value[`PAB_B4] = timer1CmpA;
        out_value_override_enable[`PAB_B3] = enB & sel_q[`PAB_S_BV];
        out_value_override_value[`PAB_B3] = timer1CmpB;
        // Bit 2: serial clock
        direction_override_enable[`PAB_B2] = twoPos;
        direction_override_value[`PAB_B2] = (serialClockStretch | bOut_q[`PAB_B2])
            & bDir_q[`PAB_B2];
        out_value_override_enable[`PAB_B2] = (twoPos & bDir_q[`PAB_B2])
            | (enA & sel_q[`PAB_S_AV]);
        out_value_override_value[`PAB_B2] = (twoPos & bDir_q[`PAB_B2]) ? 1'b0 : timer1CmpA;
        toggle_override_enable[`PAB_B2] = serialToggleEnable & pos;
        input_enable_override_enable[`PAB_B2] = sie & pos;
        input_enable_override_value[`PAB_B2] = sie & pos;
        // Bit 1: three-wire data out
        out_value_override_enable[`PAB_B1] = dataOutSel | (enB & sel_q[`PAB_S_BU]);
        out_value_override_value[`PAB_B1] = dataOutSel ? serialShiftOutBit : timer1CmpB;
        // Bit 0: compare A, serial data
        direction_override_enable[`PAB_B0] = twoPos;
        direction_override_value[`PAB_B0] = (serialShiftOutBit | bOut_q[`PAB_B0])
            & bDir_q[`PAB_B0];
        out_value_override_enable[`PAB_B0] = (twoPos & bDir_q[`PAB_B0])
            | (enA & sel_q[`PAB_S_AU]);
        out_value_override_value[`PAB_B0] = (twoPos & bDir_q[`PAB_B0]) ? 1'b0 : timer1CmpA;
        input_enable_override_enable[`PAB_B0] = (sie & pos) | (pin_change_group1_enable & mask8);
        input_enable_override_value[`PAB_B0] = (sie & pos) | (pin_change_group1_enable & mask8);
    end

    // Combine overrides with the normal port settings
    wire [7:0] effDir = (direction_override_enable & direction_override_value) | (~direction_override_enable & bDir_q);
    wire [7:0] effOut = (out_value_override_enable & out_value_override_value) | (~out_value_override_enable & bOut_q);
    // No pull-up override on any bit; pull-up only on an input
    assign portBPullUp = bOut_q & ~effDir;
    assign portBOut = effOut;
    assign portBOutEnN = ~effDir;
    assign portBToggle = toggle_override_enable;
    // Digital input enabled by default unless overridden
    assign portBInputEnable = (input_enable_override_enable & input_enable_override_value) | ~input_enable_override_enable;
    // Three-wire input does not touch port control; software keeps bit 0 in
    assign serialDataIn = bSync[`PAB_B0];
    assign serialClockIn = bSync[`PAB_B2];
    assign pinChangeSourceEight = bSync[`PAB_B0];
endmodule // pab_port_ab

//--- pab_map.vh
// Register map and field constants for the two-port pin logic
`ifndef PAB_MAP_VH
`define PAB_MAP_VH
`define PAB_ADDR_W 4
`define PAB_OFS_A_OUT 4'h0
`define PAB_OFS_A_DIR 4'h1
`define PAB_OFS_A_PIN 4'h2
`define PAB_OFS_B_OUT 4'h3
`define PAB_OFS_B_DIR 4'h4
`define PAB_OFS_B_PIN 4'h5
`define PAB_OFS_CTRL 4'h6
`define PAB_OFS_SEL 4'h7
`define PAB_RST_BYTE 8'h00
`define PAB_ZERO_HI 24'h000000
`define PAB_ZERO_BYTE 8'h00
// Control register fields
`define PAB_C_TWO 0
`define PAB_C_THREE 1
`define PAB_C_POS 2
`define PAB_C_SIE 3
`define PAB_C_PIN_CHANGE_GROUP1_ENABLE 4
`define PAB_C_MASK8 5
`define PAB_C_ENA 6
`define PAB_C_ENB 7
// Pin-select fields: A at U,V,W,X bits 0..3, B at bits 4..7
`define PAB_S_AU 0
`define PAB_S_AV 1
`define PAB_S_AW 2
`define PAB_S_AX 3
`define PAB_S_BU 4
`define PAB_S_BV 5
`define PAB_S_BW 6
`define PAB_S_BX 7
`define PAB_B0 0
`define PAB_B1 1
`define PAB_B2 2
`define PAB_B3 3
`define PAB_B4 4
`define PAB_B5 5
`define PAB_B6 6
`define PAB_B7 7
`endif

//--- pab_pin_sync.v
// Three-stage input synchroniser with agreement check
`timescale 1ns/10ps
module pab_pin_sync (
    clk,
    srst,
    clkEn,
    din,
    dout
);
    parameter W = 8;
    input wire clk;
    input wire srst;
    input wire clkEn;
    input wire [W-1:0] din;
    output reg [W-1:0] dout;
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    integer i;
    always @(posedge clk) begin
        if (srst) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
            s3_q <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else if (clkEn) begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Change counts only once stages two and three agree
            for (i = 0; i < W; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    dout[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // pab_pin_sync

//--- pab_asserts.sv
// Concurrent checks on the two-port pin logic
`timescale 1ns/10ps
`include "pab_map.vh"
module pab_asserts (
    input wire clk,
    input wire srst,
    input wire clkEn,
    input wire [`PAB_ADDR_W-1:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWriteData,
    input wire [3:0] avsByteEnable,
    input wire [31:0] avsReadData,
    input wire avsWaitRequest,
    input wire [7:0] portBIn,
    input wire [7:0] portAOut,
    input wire [7:0] portAOutEnN,
    input wire [7:0] portAPullUp,
    input wire [7:0] portBOut,
    input wire [7:0] portBOutEnN,
    input wire [7:0] portBPullUp,
    input wire [7:0] portBToggle,
    input wire [7:0] portBInputEnable,
    input wire pinChangeSourceEight
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire taken = avsWaitRequest && (avsRead || avsWrite);
    a_wait_one: assert property (taken |=> !avsWaitRequest)
        else $error("Access waited more than one cycle");
    a_rst_clear: assert property (disable iff (1'b0) srst |=>
        portAOutEnN == 8'hff && portBOutEnN == 8'hff && portAOut == 8'h00)
        else $error("Reset left a pin driven");
    a_rd_upper: assert property (avsReadData[31:8] == 24'h000000)
        else $error("Read data upper bits set");
    a_pull_a: assert property (portAPullUp == (portAOut & portAOutEnN))
        else $error("Port A pull-up wrong");
    a_pull_b: assert property ((portBPullUp & ~portBOutEnN) == 8'h00)
        else $error("Port B pull-up while driving");
    a_unmapped_rd: assert property (taken && avsRead && avsAddress[3]
        |=> avsReadData == 32'h00000000)
        else $error("Unmapped read not zero");
    a_toggle_a: assert property (taken && avsWrite && avsByteEnable[0]
        && avsAddress == `PAB_OFS_A_PIN
        |=> portAOut == ($past(portAOut) ^ $past(avsWriteData[7:0])))
        else $error("Pin write did not toggle output");
    a_no_toggle: assert property ((portBToggle & 8'hfb) == 8'h00)
        else $error("Toggle override on wrong bit");
    a_input_en: assert property (portBInputEnable == 8'hff)
        else $error("Digital input disabled");
    a_sync_b0: assert property ((clkEn && $stable(portBIn[0])) [*7]
        |-> pinChangeSourceEight == portBIn[0])
        else $error("Pin change source lags input");
    c_rd: cover property (taken && avsRead);
    c_drv_low: cover property (!portBOutEnN[0] && !portBOut[0]);
    c_tgl: cover property (portBToggle[2]);
endmodule // pab_asserts
bind pab_port_ab pab_asserts i_pab_asserts (.clk(clk), .srst(srst),
    .clkEn(clkEn),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .portBIn(portBIn), .portAOut(portAOut), .portAOutEnN(portAOutEnN),
    .portAPullUp(portAPullUp), .portBOut(portBOut),
    .portBOutEnN(portBOutEnN), .portBPullUp(portBPullUp),
    .portBToggle(portBToggle), .portBInputEnable(portBInputEnable),
    .pinChangeSourceEight(pinChangeSourceEight));

//--- pab_pin_model.sv
// Pad model: level from own driver, outside source or pull-up
`timescale 1ns/10ps
module pab_pin_model (
    input wire clk,
    input wire [7:0] drvOut,
    input wire [7:0] drvEnN,
    input wire [7:0] pullUp,
    input wire [7:0] extVal,
    input wire [7:0] extDrive,
    output wire [7:0] pinLevel
);
    logic [7:0] last_q = 8'h00;
    wire [7:0] own = ~drvEnN & drvOut;
    wire [7:0] ext = drvEnN & extDrive & extVal;
    // Floating pad shows the pull-up, else the inverse, so a stale level never passes
    wire [7:0] flt = drvEnN & ~extDrive & (pullUp | ~last_q);
    assign pinLevel = own | ext | flt;
    always @(posedge clk) begin
        last_q <= pinLevel;
    end
endmodule // pab_pin_model

//--- testbench.sv
// Register and override tests for the two-port pin logic
`timescale 1ns/10ps
module testbench;
    logic clk, srst, avsRead, avsWrite, tA, tB, shOut, sHold, sTgl;
    logic clkEn;
    logic [3:0] avsAddress, avsByteEnable;
    logic [31:0] avsWriteData, rdat;
    logic [7:0] extA, extB;
    wire [31:0] avsReadData;
    wire avsWaitRequest, sdIn, scIn, pcs8;
    wire [7:0] aIn, aOut, aEnN, aPu, bIn, bOut, bEnN, bPu, bTgl, bIe;
    int errorCnt = 0;
    int nTests = 0;
    pab_port_ab i_pab_port_ab (.clk(clk), .srst(srst), .clkEn(clkEn),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .timer1CmpA(tA), .timer1CmpB(tB), .serialShiftOutBit(shOut),
        .serialClockStretch(sHold), .serialToggleEnable(sTgl),
        .portAIn(aIn), .portAOut(aOut), .portAOutEnN(aEnN),
        .portAPullUp(aPu), .portBIn(bIn), .portBOut(bOut),
        .portBOutEnN(bEnN), .portBPullUp(bPu), .portBToggle(bTgl),
        .portBInputEnable(bIe), .serialDataIn(sdIn),
        .serialClockIn(scIn), .pinChangeSourceEight(pcs8));
    pab_pin_model i_pab_pin_model_a (.clk(clk), .drvOut(aOut),
        .drvEnN(aEnN), .pullUp(aPu), .extVal(extA), .extDrive(8'hff),
        .pinLevel(aIn));
    pab_pin_model i_pab_pin_model_b (.clk(clk), .drvOut(bOut),
        .drvEnN(bEnN), .pullUp(bPu), .extVal(extB), .extDrive(8'hff),
        .pinLevel(bIn));
    task summarize;
        $display("Checks %0d, errors %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            errorCnt++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Holds the request until waitrequest is seen low at an edge
    task acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        avsAddress <= a;
        avsWriteData <= {24'h000000, d};
        avsWrite <= wr;
        avsRead <= !wr;
        do @(posedge clk); while (avsWaitRequest !== 1'b0);
        rdat = avsReadData;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(rdat, {24'h000000, e});
    endtask
    task settle;
        @(posedge clk);
        @(negedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        errorCnt++;
        summarize;
    end
    initial begin
        {srst, avsRead, avsWrite, tA, tB, shOut, sHold, sTgl} = 8'h80;
        {avsAddress, avsByteEnable, avsWriteData} = 40'h0100000000;
        clkEn = 1'b1;
        extA = 8'h3c;
        extB = 8'h81;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i != 2 && i != 5) rd(4'(i), 8'h00);
        end
        foreach (rdat[i]) begin
            if (i < 5 && i != 2) begin
                acc(1'b1, 4'(i), 8'ha5);
                rd(4'(i), 8'ha5);
                acc(1'b1, 4'(i), 8'h00);
            end
        end
        acc(1'b1, 4'h9, 8'hff);
        rd(4'h9, 8'h00);
        avsByteEnable <= 4'h0;
        acc(1'b1, 4'h0, 8'hff);
        avsByteEnable <= 4'h1;
        rd(4'h0, 8'h00);
        rd(4'h5, 8'h81);
        chk({sdIn, scIn}, 2'b10);
        acc(1'b1, 4'h1, 8'hf0);
        acc(1'b1, 4'h0, 8'ha0);
        repeat (8) @(posedge clk);
        rd(4'h2, 8'hac);
        acc(1'b1, 4'h2, 8'h0f);
        rd(4'h0, 8'haf);
        acc(1'b1, 4'h5, 8'h03);
        rd(4'h3, 8'h03);
        acc(1'b1, 4'h3, 8'h00);
        acc(1'b1, 4'h4, 8'hff);
        acc(1'b1, 4'h6, 8'hc0);
        acc(1'b1, 4'h7, 8'hff);
        tA <= 1'b1;
        settle;
        chk(bOut, 8'h55);
        tA <= 1'b0;
        tB <= 1'b1;
        settle;
        chk(bOut, 8'haa);
        acc(1'b1, 4'h6, 8'h40);
        settle;
        chk(bOut, 8'h00);
        acc(1'b1, 4'h3, 8'h05);
        acc(1'b1, 4'h4, 8'h05);
        acc(1'b1, 4'h6, 8'h05);
        acc(1'b1, 4'h7, 8'h00);
        settle;
        chk({bOut, bEnN}, 16'h00fa);
        acc(1'b1, 4'h3, 8'h00);
        settle;
        chk(bEnN, 8'hff);
        {shOut, sHold, sTgl} <= 3'b111;
        settle;
        chk({bEnN, bTgl}, 16'hfa04);
        acc(1'b1, 4'h4, 8'h02);
        acc(1'b1, 4'h6, 8'h07);
        settle;
        chk(bOut[1], 1'b1);
        acc(1'b1, 4'h3, 8'h02);
        acc(1'b1, 4'h4, 8'h00);
        settle;
        chk(bPu, 8'h02);
        // Frozen enable must hold the synchronised level
        clkEn <= 1'b0;
        extB <= 8'h00;
        repeat (8) @(posedge clk);
        chk(pcs8, 1'b1);
        clkEn <= 1'b1;
        repeat (8) @(posedge clk);
        chk(pcs8, 1'b0);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        rd(4'h1, 8'h00);
        rd(4'h4, 8'h00);
        summarize;
    end
endmodule // testbench
